// File: bench/mcuio_board.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// board model: resolves the pin levels that the ports read back
module mcuio_board
  import mcuio_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // bus port zero
  input  wire logic [7:0] p0_o,
  input  wire logic [7:0] p0_oe,
  input  wire logic [7:0] p0_ev,
  input  wire logic [7:0] p0_en,
  output var  logic [7:0] p0_pin,
  // quasi port one
  input  wire logic [7:0] p1_o,
  input  wire logic [7:0] p1_oe,
  input  wire logic [7:0] p1_pw,
  input  wire logic [7:0] p1_ps,
  input  wire logic [7:0] p1_ev,
  input  wire logic [7:0] p1_en,
  output var  logic [7:0] p1_pin
);
  logic [7:0] p0_last_q = 8'h00;
  logic [7:0] p1_last_q = 8'h00;

  // a line nobody drives or pulls up shows the inverse of its last level, so a stale value never reads as valid
  always_comb begin
    p0_pin = (p0_oe & p0_o) | (~p0_oe & p0_en & p0_ev) | (~p0_oe & ~p0_en & ~p0_last_q);
    p1_pin = (p1_oe & p1_o) | (~p1_oe & p1_en & p1_ev) | (~p1_oe & ~p1_en & (p1_pw | p1_ps | ~p1_last_q));
  end

  always_ff @(posedge clk_sys) begin
    p0_last_q <= p0_pin;
    p1_last_q <= p1_pin;
  end
endmodule // mcuio_board
`default_nettype wire

// File: bench/tb_mcuio_ports.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mcuio_ports
  import mcuio_pkg::*;
();
  logic        clk_sys, rstn, cyc, stb, we, ack, ext_rom, ph_a, ph_w, ph_r, pdown, t2_clk, t2_cap;
  logic [7:0]  adr, m_adr, m_wd, m_rd, p0_i, p0_o, p0_oe, p1_i, p1_o, p1_oe, pu_w, pu_s;
  logic [7:0]  p0_ev, p0_en, p1_ev, p1_en;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dat_o;
  int          mismatches, check_count;

  mcuio_ports u_dut (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext_rom_mode(ext_rom), .mem_addr_phase(ph_a), .mem_write_phase(ph_w), .mem_read_phase(ph_r),
    .mem_addr_lo(m_adr), .mem_wdata(m_wd), .mem_rdata(m_rd), .power_down(pdown),
    .timer_two_clock_input(t2_clk), .timer_two_capture_reload_input(t2_cap),
    .bus_port_zero_i(p0_i), .bus_port_zero_o(p0_o), .bus_port_zero_oe(p0_oe),
    .quasi_port_one_i(p1_i), .quasi_port_one_o(p1_o), .quasi_port_one_oe(p1_oe),
    .quasi_port_one_pu_weak(pu_w), .quasi_port_one_pu_strong(pu_s));

  mcuio_board u_board (.clk_sys(clk_sys), .p0_o(p0_o), .p0_oe(p0_oe), .p0_ev(p0_ev), .p0_en(p0_en),
    .p0_pin(p0_i), .p1_o(p1_o), .p1_oe(p1_oe), .p1_pw(pu_w), .p1_ps(pu_s), .p1_ev(p1_ev),
    .p1_en(p1_en), .p1_pin(p1_i));

  // ==========================================
  // checking and bus tasks
  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // classic cycle: request held until ack is sampled, data taken at that same edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'h1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("Error wb_ack expected 1 seen %h", ack);
    end
    rdat = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'h1, a, d, 4'h1);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    wb(1'h0, a, 8'h00, 4'h1);
    chk(nm, rdat, {24'h000000, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    rdchk("p0_latch", MCUIO_OFS_P0_LATCH, 8'hFF);
    rdchk("p1_latch", MCUIO_OFS_P1_LATCH, 8'hFF);
    rdchk("io_ctrl", MCUIO_OFS_IO_CTRL, 8'h00);
    rdchk("p1_pins", MCUIO_OFS_P1_PIN, 8'hFF);
    rdchk("status", MCUIO_OFS_STATUS, 8'h01);
    rdchk("unmapped", 8'h20, 8'h00);
  endtask

  task automatic t_refuse();
    wb(1'h1, MCUIO_OFS_P1_LATCH, 8'h00, 4'h0);
    rdchk("sel_off", MCUIO_OFS_P1_LATCH, 8'hFF);
    wr(MCUIO_OFS_P1_PIN, 8'h00);
    rdchk("ro_pins", MCUIO_OFS_P1_PIN, 8'hFF);
    ext_rom <= 1'h0;
    rdchk("status_int", MCUIO_OFS_STATUS, 8'h00);
    ext_rom <= 1'h1;
    wr(MCUIO_OFS_IO_CTRL, 8'hE0);
    rdchk("io_store", MCUIO_OFS_IO_CTRL, 8'hE0);
    wr(MCUIO_OFS_IO_CTRL, 8'h00);
  endtask

  task automatic t_bus_port();
    wr(MCUIO_OFS_P0_LATCH, 8'h5A);
    tick(1);
    chk("p0_oe", p0_oe, 8'hA5);
    chk("p0_high", p0_o & p0_oe, 8'h00);
    wr(MCUIO_OFS_P0_LATCH, 8'hFF);
    p0_ev <= 8'h3C;
    p0_en <= 8'hFF;
    tick(4);
    chk("p0_float", p0_oe, 8'h00);
    rdchk("p0_pins", MCUIO_OFS_P0_PIN, 8'h3C);
    p0_en <= 8'h00;
  endtask

  task automatic t_ext_mem();
    wr(MCUIO_OFS_P0_LATCH, 8'h00);
    ph_a  <= 1'h1;
    m_adr <= 8'hC3;
    tick(2);
    chk("addr_oe", p0_oe, 8'hFF);
    chk("addr_lo", p0_o, 8'hC3);
    ph_a <= 1'h0;
    ph_w <= 1'h1;
    m_wd <= 8'h81;
    tick(2);
    chk("wdata", p0_o, 8'h81);
    ph_w  <= 1'h0;
    ph_r  <= 1'h1;
    p0_ev <= 8'h6E;
    p0_en <= 8'hFF;
    tick(5);
    chk("rd_oe", p0_oe, 8'h00);
    chk("rd_data", m_rd, 8'h6E);
    ph_r  <= 1'h0;
    p0_en <= 8'h00;
    rdchk("p0_refill", MCUIO_OFS_P0_LATCH, 8'hFF);
  endtask

  task automatic t_quasi();
    int n;
    n = 0;
    wr(MCUIO_OFS_P1_LATCH, 8'h00);
    tick(1);
    chk("p1_low_oe", p1_oe, 8'hFF);
    chk("p1_low", p1_o, 8'h00);
    wr(MCUIO_OFS_P1_LATCH, 8'hFF);
    repeat (6) begin
      @(posedge clk_sys);
      if (p1_oe === 8'hFF && p1_o === 8'hFF) n++;
    end
    chk("accel_len", n, 32'h2);
    chk("p1_idle_oe", p1_oe, 8'h00);
    chk("p1_pu_weak", pu_w, 8'hFF);
    rdchk("p1_hold", MCUIO_OFS_P1_LATCH, 8'hFF);
    n = 0;
    wr(MCUIO_OFS_P1_LATCH, 8'h55);
    repeat (4) begin
      @(posedge clk_sys);
      if ((p1_oe & 8'h55) !== 8'h00) n++;
    end
    chk("no_accel", n, 32'h0);
    chk("p1_mix_oe", p1_oe, 8'hAA);
  endtask

  task automatic t_pullup();
    wr(MCUIO_OFS_P1_LATCH, 8'hFF);
    p1_ev <= 8'h00;
    p1_en <= 8'h04;
    tick(4);
    chk("pu_s_low", pu_s, 8'hFB);
    chk("pu_w_low", pu_w, 8'hFF);
    rdchk("p1_in", MCUIO_OFS_P1_PIN, 8'hFB);
    p1_en <= 8'h00;
    tick(4);
    chk("pu_s_back", pu_s, 8'hFF);
    wr(MCUIO_OFS_IO_CTRL, 8'h10);
    tick(1);
    chk("pu_reduced", pu_s, 8'h00);
    chk("pu_w_kept", pu_w, 8'hFF);
    wr(MCUIO_OFS_IO_CTRL, 8'h00);
  endtask

  task automatic t_highz();
    wr(MCUIO_OFS_P1_LATCH, 8'h00);
    wr(MCUIO_OFS_IO_CTRL, 8'h02);
    p1_ev <= 8'hA5;
    p1_en <= 8'hFF;
    tick(4);
    chk("hz_oe", p1_oe, 8'h00);
    chk("hz_pu", pu_w | pu_s, 8'h00);
    rdchk("hz_pins", MCUIO_OFS_P1_PIN, 8'hA5);
    p1_en <= 8'h00;
    wr(MCUIO_OFS_IO_CTRL, 8'h00);
    wr(MCUIO_OFS_P1_LATCH, 8'hFF);
  endtask

  task automatic t_timer();
    p1_ev <= 8'h01;
    p1_en <= 8'h03;
    // the latch write just before still accelerates the pins for two cycles
    tick(6);
    chk("t2_a", {t2_cap, t2_clk}, 2'h1);
    p1_ev <= 8'h02;
    tick(4);
    chk("t2_b", {t2_cap, t2_clk}, 2'h2);
    p1_en <= 8'h00;
  endtask

  task automatic t_pdown();
    wr(MCUIO_OFS_P0_LATCH, 8'h00);
    wr(MCUIO_OFS_IO_CTRL, 8'h01);
    pdown <= 1'h1;
    tick(3);
    chk("pd_p0", p0_oe, 8'h00);
    chk("pd_p1", p1_oe | pu_w | pu_s, 8'h00);
    rdchk("pd_status", MCUIO_OFS_STATUS, 8'h07);
    // the float choice must stay fixed once power down has begun
    wr(MCUIO_OFS_IO_CTRL, 8'h00);
    tick(1);
    chk("pd_fixed", p0_oe, 8'h00);
    pdown <= 1'h0;
    tick(2);
    chk("pd_exit", p0_oe, 8'hFF);
    pdown <= 1'h1;
    tick(3);
    chk("pd_driven", p0_oe, 8'hFF);
    pdown <= 1'h0;
  endtask

  // ==========================================
  // clock, watchdog and main sequence
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    tick(5000);
    mismatches++;
    report_and_stop();
  end

  initial begin
    {rstn, cyc, stb, we, ph_a, ph_w, ph_r, pdown} = 8'h00;
    ext_rom = 1'h1;
    {adr, m_adr, m_wd, p0_ev, p0_en, p1_ev, p1_en} = 56'h0;
    sel  = 4'h0;
    wdat = 32'h0;
    mismatches  = 0;
    check_count = 0;
    tick(5);
    rstn <= 1'h1;
    t_reset();
    t_refuse();
    t_bus_port();
    t_ext_mem();
    t_quasi();
    t_pullup();
    t_highz();
    t_timer();
    t_pdown();
    report_and_stop();
  end
endmodule // tb_mcuio_ports
`default_nettype wire

// File: src/mcuio_pkg.sv
`default_nettype none
package mcuio_pkg;

  // ==========================================================
  // widths
  typedef logic [7:0]  mcuio_byte_t;
  typedef logic [31:0] mcuio_word_t;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] MCUIO_OFS_P0_LATCH = 8'h00;
  localparam logic [7:0] MCUIO_OFS_P1_LATCH = 8'h04;
  localparam logic [7:0] MCUIO_OFS_P0_PIN   = 8'h08;
  localparam logic [7:0] MCUIO_OFS_P1_PIN   = 8'h0C;
  localparam logic [7:0] MCUIO_OFS_STATUS   = 8'h10;
  localparam logic [7:0] MCUIO_OFS_IO_CTRL  = 8'hF8;

  // ==========================================================
  // io_control fields
  localparam int unsigned MCUIO_BIT_PD_FLOAT   = 0;
  localparam int unsigned MCUIO_BIT_P1_HIGHZ   = 1;
  localparam int unsigned MCUIO_BIT_PU_DISABLE = 4;

  // status fields
  localparam int unsigned MCUIO_BIT_ST_EXT   = 0;
  localparam int unsigned MCUIO_BIT_ST_FLOAT = 1;
  localparam int unsigned MCUIO_BIT_ST_PD    = 2;

  // ==========================================================
  // reset values
  localparam mcuio_byte_t MCUIO_RST_LATCH   = 8'hFF;
  localparam mcuio_byte_t MCUIO_RST_IO_CTRL = 8'h00;
  localparam mcuio_byte_t MCUIO_ALL_ONES    = 8'hFF;
  localparam mcuio_byte_t MCUIO_ALL_ZERO    = 8'h00;

  // ==========================================================
  // timing: accelerator length in oscillator periods
  localparam int unsigned MCUIO_ACCEL_PERIODS = 2;
  localparam int unsigned MCUIO_CLK_PER_OSC   = 1;
  localparam logic [1:0]  MCUIO_ACCEL_CYCLES  = 2'(MCUIO_ACCEL_PERIODS * MCUIO_CLK_PER_OSC);

endpackage : mcuio_pkg
`default_nettype wire

// File: src/mcuio_ports.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - internal mode, bus port output is open drain, pulls low only.
// - external memory cycles drive address and write data push-pull.
// - bus port goes tri-state while external read data is taken in.
// - reset and every external access load ones into the bus port latch.
// - bus port is general port, low address and data; pin n is bit n.
// - quasi port pin with latch one has an internal pull-up.
// - quasi port output drives both low and high levels.
// - latch zero-to-one change gives a strong high drive for two periods.
// - a written latch value holds and drives until the next write.
// - strong pull-up off while pin reads low, back on when high.
// - port-one high-impedance bit removes all port-one drivers and pull-ups.
// - port-one bit 0 feeds timer two clock, bit 1 its capture input.
// - float bit set at power down entry floats all outputs during it.
// - pull-up reduction bit removes the strong pull-ups.
module mcuio_ports
  import mcuio_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // cpu side of external memory cycles
  input  wire logic        ext_rom_mode,
  input  wire logic        mem_addr_phase,
  input  wire logic        mem_write_phase,
  input  wire logic        mem_read_phase,
  input  wire logic [7:0]  mem_addr_lo,
  input  wire logic [7:0]  mem_wdata,
  output var  logic [7:0]  mem_rdata,
  // power down
  input  wire logic        power_down,
  // timer two alternate inputs
  output var  logic        timer_two_clock_input,
  output var  logic        timer_two_capture_reload_input,
  // bus port zero pins
  input  wire logic [7:0]  bus_port_zero_i,
  output var  logic [7:0]  bus_port_zero_o,
  output var  logic [7:0]  bus_port_zero_oe,
  // quasi port one pins
  input  wire logic [7:0]  quasi_port_one_i,
  output var  logic [7:0]  quasi_port_one_o,
  output var  logic [7:0]  quasi_port_one_oe,
  output var  logic [7:0]  quasi_port_one_pu_weak,
  output var  logic [7:0]  quasi_port_one_pu_strong
);

  typedef struct packed {
    logic        ack;
    mcuio_word_t rdat;
    mcuio_byte_t p0_lat;
    mcuio_byte_t p1_lat;
    mcuio_byte_t io_control;
    logic        pd_prev;
    logic        pd_float;
    mcuio_byte_t rdata;
  } mcuio_state_t;

  mcuio_state_t st_q;
  mcuio_state_t st_d;

  mcuio_qbit_if qb ();

  logic [15:0] pin_s;
  mcuio_byte_t p0_s;
  mcuio_byte_t p1_s;
  logic        req;
  logic        wr_take;
  logic        mem_access;
  logic        p1_wr;

  // ==========================================================
  // read mux, shared by the bus answer and nothing else for now
  function automatic mcuio_word_t rd_mux(input logic [7:0] adr, input mcuio_state_t s,
                                         input mcuio_byte_t ps0, input mcuio_byte_t ps1,
                                         input logic ext, input logic pd);
    mcuio_word_t r;
    r = '0;
    case (adr)
      MCUIO_OFS_P0_LATCH: r[7:0] = s.p0_lat;
      MCUIO_OFS_P1_LATCH: r[7:0] = s.p1_lat;
      MCUIO_OFS_P0_PIN:   r[7:0] = ps0;
      MCUIO_OFS_P1_PIN:   r[7:0] = ps1;
      MCUIO_OFS_STATUS: begin
        r[MCUIO_BIT_ST_EXT]   = ext;
        r[MCUIO_BIT_ST_FLOAT] = s.pd_float;
        r[MCUIO_BIT_ST_PD]    = pd;
      end
      MCUIO_OFS_IO_CTRL:  r[7:0] = s.io_control;
      default:            r = '0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // input synchronizers
  mcuio_sync u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       ({quasi_port_one_i, bus_port_zero_i}),
    .q       (pin_s)
  );

  assign p0_s = pin_s[7:0];
  assign p1_s = pin_s[15:8];

  // ==========================================================
  // bus handshake: ack one cycle after the request, write at the ack edge
  assign req        = wb_cyc_i & wb_stb_i;
  assign wr_take    = req & wb_we_i & st_q.ack & wb_sel_i[0];
  assign mem_access = mem_addr_phase | mem_write_phase | mem_read_phase;
  assign p1_wr      = wr_take & (wb_adr_i == MCUIO_OFS_P1_LATCH);

  // ==========================================================
  // state update
  always_comb begin
    st_d     = st_q;
    st_d.ack = req & ~st_q.ack;
    if (req & ~st_q.ack) begin
      st_d.rdat = rd_mux(wb_adr_i, st_q, p0_s, p1_s, ext_rom_mode, power_down);
    end
    if (wr_take) begin
      case (wb_adr_i)
        MCUIO_OFS_P0_LATCH: st_d.p0_lat     = wb_dat_i[7:0];
        MCUIO_OFS_P1_LATCH: st_d.p1_lat     = wb_dat_i[7:0];
        MCUIO_OFS_IO_CTRL:  st_d.io_control = wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
    // an external cycle wins over a software write in the same cycle
    if (mem_access) begin
      st_d.p0_lat = MCUIO_ALL_ONES;
    end
    if (mem_read_phase) begin
      st_d.rdata = p0_s;
    end
    // float choice is frozen at entry; later writes do not change it
    st_d.pd_prev = power_down;
    if (!power_down) begin
      st_d.pd_float = 1'b0;
    end else if (!st_q.pd_prev) begin
      st_d.pd_float = st_q.io_control[MCUIO_BIT_PD_FLOAT];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q            <= '0;
      st_q.p0_lat     <= MCUIO_RST_LATCH;
      st_q.p1_lat     <= MCUIO_RST_LATCH;
      st_q.io_control <= MCUIO_RST_IO_CTRL;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o  = st_q.ack;
  assign wb_dat_o  = st_q.rdat;
  assign mem_rdata = st_q.rdata;

  // ==========================================================
  // bus port zero drivers
  always_comb begin
    bus_port_zero_o  = MCUIO_ALL_ZERO;
    bus_port_zero_oe = MCUIO_ALL_ZERO;
    if (st_q.pd_float) begin
      bus_port_zero_oe = MCUIO_ALL_ZERO;
    end else if (mem_read_phase) begin
      bus_port_zero_oe = MCUIO_ALL_ZERO;
    end else if (mem_addr_phase) begin
      bus_port_zero_o  = mem_addr_lo;
      bus_port_zero_oe = MCUIO_ALL_ONES;
    end else if (mem_write_phase) begin
      bus_port_zero_o  = mem_wdata;
      bus_port_zero_oe = MCUIO_ALL_ONES;
    end else begin
      // open drain: a one in the latch releases the pin
      bus_port_zero_o  = MCUIO_ALL_ZERO;
      bus_port_zero_oe = ~st_q.p0_lat;
    end
  end

  // ==========================================================
  // quasi port one
  assign qb.latch    = st_q.p1_lat;
  assign qb.pin_s    = p1_s;
  assign qb.highz    = st_q.io_control[MCUIO_BIT_P1_HIGHZ];
  assign qb.pd_float = st_q.pd_float;
  assign qb.pu_dis   = st_q.io_control[MCUIO_BIT_PU_DISABLE];

  mcuio_quasi u_quasi (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .qb      (qb.drv)
  );

  assign quasi_port_one_o         = qb.drv_o;
  assign quasi_port_one_oe        = qb.drv_oe;
  assign quasi_port_one_pu_weak   = qb.pu_weak;
  assign quasi_port_one_pu_strong = qb.pu_strong;

  // timer two sees the pin itself; a zero latch holds it low on the wire unless the port is high-impedance or floated
  assign timer_two_clock_input          = p1_s[0];
  assign timer_two_capture_reload_input = p1_s[1];

  // ==========================================================
  // checks
  AST_P0_OPEN_DRAIN: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!mem_access && !st_q.pd_float) |->
    (bus_port_zero_oe == ~st_q.p0_lat) && (bus_port_zero_o == MCUIO_ALL_ZERO))
    else $error("bus port drives high in port mode");

  AST_P0_PUSH_PULL: assert property (@(posedge clk_sys) disable iff (!rstn)
    (mem_addr_phase && !mem_read_phase && !st_q.pd_float) |->
    (bus_port_zero_oe == MCUIO_ALL_ONES) && (bus_port_zero_o == mem_addr_lo))
    else $error("address not driven push-pull");

  AST_P0_WDATA: assert property (@(posedge clk_sys) disable iff (!rstn)
    (mem_write_phase && !mem_addr_phase && !mem_read_phase && !st_q.pd_float) |->
    (bus_port_zero_oe == MCUIO_ALL_ONES) && (bus_port_zero_o == mem_wdata))
    else $error("write data not on the bus port");

  AST_P0_READ_TRI: assert property (@(posedge clk_sys) disable iff (!rstn)
    mem_read_phase |-> (bus_port_zero_oe == MCUIO_ALL_ZERO))
    else $error("bus port not tri-state during a read");

  // capture is only promised while the read phase is held through the two sync stages
  AST_P0_READ_DATA: assert property (@(posedge clk_sys) disable iff (!rstn)
    mem_read_phase[*3] |=> (mem_rdata == $past(bus_port_zero_i, 3)))
    else $error("read data lost");

  AST_P0_LATCH_ONES: assert property (@(posedge clk_sys) disable iff (!rstn)
    mem_access |=> (st_q.p0_lat == MCUIO_ALL_ONES)) else $error("bus latch not set to ones");

  AST_P1_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    !p1_wr |=> $stable(st_q.p1_lat)) else $error("port one latch changed without a write");

  AST_P1_LATCH_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    p1_wr |=> (st_q.p1_lat == $past(wb_dat_i[7:0]))) else $error("port one write lost");

  AST_PD_FLOAT: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($rose(power_down) && st_q.io_control[MCUIO_BIT_PD_FLOAT]) ##1 power_down |->
    (bus_port_zero_oe == MCUIO_ALL_ZERO) && (quasi_port_one_oe == MCUIO_ALL_ZERO)
    && (quasi_port_one_pu_weak == MCUIO_ALL_ZERO)) else $error("ports not floated in power down");

  AST_P1_PULLUP: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!st_q.pd_float && !qb.highz) |-> (quasi_port_one_pu_weak == st_q.p1_lat))
    else $error("pull-up does not follow the latch");

  AST_P1_DRIVE_LOW: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!st_q.pd_float && !qb.highz) |-> ((quasi_port_one_oe & ~st_q.p1_lat) == ~st_q.p1_lat)
    && ((quasi_port_one_o & quasi_port_one_oe) == (st_q.p1_lat & quasi_port_one_oe)))
    else $error("quasi port does not drive its latch level");

  AST_T2_INPUTS: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(rstn) |-> ##2 (timer_two_clock_input == $past(quasi_port_one_i[0], 2))
    && (timer_two_capture_reload_input == $past(quasi_port_one_i[1], 2)))
    else $error("timer two inputs not fed from port one");

  AST_WB_ACK: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");

endmodule : mcuio_ports
`default_nettype wire

// File: src/mcuio_qbit_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mcuio_qbit_if;
  logic [7:0] latch;
  logic [7:0] pin_s;
  logic       highz;
  logic       pd_float;
  logic       pu_dis;
  logic [7:0] drv_o;
  logic [7:0] drv_oe;
  logic [7:0] pu_weak;
  logic [7:0] pu_strong;
  logic [7:0] accel;

  modport ctl (output latch, pin_s, highz, pd_float, pu_dis,
               input  drv_o, drv_oe, pu_weak, pu_strong, accel);
  modport drv (input  latch, pin_s, highz, pd_float, pu_dis,
               output drv_o, drv_oe, pu_weak, pu_strong, accel);
endinterface : mcuio_qbit_if
`default_nettype wire

// File: src/mcuio_quasi.sv
`timescale 1ns/1ps
`default_nettype none
module mcuio_quasi
  import mcuio_pkg::*;
(
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   rstn,
  // port controls and drivers
  mcuio_qbit_if.drv   qb
);

  typedef struct packed {
    logic [7:0]      prev;
    logic [7:0][1:0] cnt;
  } mcuio_quasi_t;

  mcuio_quasi_t st_q;
  mcuio_quasi_t st_d;
  logic         off;

  assign off = qb.highz | qb.pd_float;

  // ==========================================================
  // accelerator counters, started only on a zero-to-one latch change
  always_comb begin
    st_d      = st_q;
    st_d.prev = qb.latch;
    for (int i = 0; i < 8; i++) begin
      if (!qb.latch[i]) begin
        st_d.cnt[i] = 2'h0;
      end else if (!st_q.prev[i]) begin
        st_d.cnt[i] = MCUIO_ACCEL_CYCLES;
      end else if (st_q.cnt[i] != 2'h0) begin
        st_d.cnt[i] = st_q.cnt[i] - 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q      <= '0;
      // prev starts at the latch reset value, else a false zero-to-one edge follows reset
      st_q.prev <= MCUIO_RST_LATCH;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // per-pin drivers
  // the accelerator stays gated by off so a floated port never pulses high
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign qb.accel[i]     = (st_q.cnt[i] != 2'h0) & ~off;
    assign qb.drv_o[i]     = qb.latch[i];
    assign qb.drv_oe[i]    = ~off & (~qb.latch[i] | qb.accel[i]);
    assign qb.pu_weak[i]   = ~off & qb.latch[i];
    assign qb.pu_strong[i] = ~off & qb.latch[i] & ~qb.pu_dis & qb.pin_s[i];

    AST_ACCEL_TWO: assert property (@(posedge clk_sys) disable iff (!rstn)
      (qb.latch[i] && !st_q.prev[i] && !off) ##1 (qb.latch[i] && !off)[*3]
      |-> $past(qb.accel[i], 1) && !qb.accel[i] && $past(qb.accel[i], 2))
      else $error("accelerator length is not two cycles");
    AST_ACCEL_ONLY_HIGH: assert property (@(posedge clk_sys) disable iff (!rstn)
      !qb.latch[i] |-> !qb.accel[i]) else $error("accelerator on with latch low");
    AST_PU_LOW_PIN: assert property (@(posedge clk_sys) disable iff (!rstn)
      (qb.latch[i] && !qb.pin_s[i]) |-> !qb.pu_strong[i] && (qb.pu_weak[i] == !off))
      else $error("strong pull-up kept on a low pin");
  end

  AST_HIGHZ_ALL_OFF: assert property (@(posedge clk_sys) disable iff (!rstn)
    qb.highz |-> (qb.drv_oe == MCUIO_ALL_ZERO) && (qb.pu_weak == MCUIO_ALL_ZERO)
    && (qb.pu_strong == MCUIO_ALL_ZERO)) else $error("high impedance port still driven");
  AST_PU_DISABLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    qb.pu_dis |-> (qb.pu_strong == MCUIO_ALL_ZERO)) else $error("strong pull-up not removed");

endmodule : mcuio_quasi
`default_nettype wire

// File: src/mcuio_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mcuio_sync
  import mcuio_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // levels
  input  wire logic [15:0] d,
  output var  logic [15:0] q
);

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
  } mcuio_sync_t;

  mcuio_sync_t st_q;
  mcuio_sync_t st_d;

  // ==========================================================
  // two stages; first stage is read by the second only
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

  AST_SYNC_DELAY: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(rstn) |-> ##2 (q == $past(d, 2))) else $error("synchronizer delay is not two cycles");

endmodule : mcuio_sync
`default_nettype wire
